// ==== logic/bwc_addr_xlate.sv ====
// address translation for the initiator path and space 1 target decode
module bwc_addr_xlate import bwc_pkg::*; (
	// register contents
	input wire logic [31:0] i_mem_remap,
	input wire logic [31:0] i_cfg_addr,
	input wire logic [31:0] i_s1_range,
	input wire logic [31:0] i_s1_remap,
	input wire logic [31:0] i_upper,
	// initiator request
	input wire logic [31:0] i_init_local_addr,
	input wire logic [15:0] i_init_range_mask,
	input wire logic i_init_is_io,
	// target request
	input wire logic [31:0] i_tgt_pci_addr,
	input wire logic [31:0] i_tgt_base,
	input wire logic i_tgt_is_io,
	// results
	output logic [31:0] o_init_pci_addr,
	output logic o_init_cfg_cycle,
	output logic o_init_dual_addr,
	output logic o_tgt_hit,
	output logic [31:0] o_tgt_local_addr
);
	logic [31:0] tmask; // decode mask for space 1
	logic s1_io; // space 1 sits in io space
	always_comb begin
		s1_io = i_s1_range[RG_IO]; // [R11]
		// memory: bits 31:4 decode; io: bits 31:2 decode [R12] [R13]
		tmask = s1_io ? {i_s1_range[31:2], 2'b00} : {i_s1_range[31:4], 4'h0};
		// hit needs enable, matching space kind and matching bits [R14]
		o_tgt_hit = i_s1_remap[RM_ENABLE] && (i_tgt_is_io == s1_io)
			&& (((i_tgt_pci_addr ^ i_tgt_base) & tmask) == RST_ZERO);
		// remap bits 3:2 only join in io mode [R15]
		o_tgt_local_addr = (i_tgt_pci_addr & ~tmask)
			| ({i_s1_remap[31:4], (s1_io ? i_s1_remap[3:2] : 2'b00), 2'b00} & tmask);
		// initiator address formation
		o_init_cfg_cycle = i_init_is_io && i_cfg_addr[CF_ENABLE]; // [R10]
		if (o_init_cfg_cycle) begin
			// bus, device, function, register and type [R10]
			o_init_pci_addr = {8'h00, i_cfg_addr[23:0]};
		end else if (i_init_is_io) begin
			// io remap select forces the upper half to zero [R07]
			o_init_pci_addr = {(i_mem_remap[MR_IO_REMAP] ? 16'h0000 : i_mem_remap[31:16]),
				i_init_local_addr[15:0]};
		end else begin
			// decoded bits are replaced by the remap value [R09]
			o_init_pci_addr = {(i_init_local_addr[31:16] & ~i_init_range_mask)
				| (i_mem_remap[31:16] & i_init_range_mask), i_init_local_addr[15:0]};
		end
		o_init_dual_addr = (i_upper != RST_ZERO); // [R22]
	end
endmodule : bwc_addr_xlate

// ==== logic/bwc_pkg.sv ====
// constants shared by the bridge window configuration bank
package bwc_pkg;
	// byte offsets, pci view
	localparam logic [8:0] OFS_MEM_REMAP = 9'h028;
	localparam logic [8:0] OFS_CFG_ADDR = 9'h02c;
	localparam logic [8:0] OFS_S1_RANGE = 9'h0f0;
	localparam logic [8:0] OFS_S1_REMAP = 9'h0f4;
	localparam logic [8:0] OFS_S1_DESC = 9'h0f8;
	localparam logic [8:0] OFS_UPPER = 9'h0fc;
	// local view sits this far above the pci view
	localparam logic [8:0] OFS_LOCAL_SHIFT = 9'h080;
	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_S1_RANGE = 32'hfff0_0000;
	localparam logic [31:0] RST_S1_DESC = 32'h0000_0043;
	// writable bit masks
	localparam logic [31:0] WM_ALL = 32'hffff_ffff;
	localparam logic [31:0] WM_CFG = 32'h80ff_ffff;
	localparam logic [31:0] WM_S1_REMAP = 32'hffff_fffd;
	localparam logic [31:0] WM_S1_DESC = 32'h0000_7fff;
	// memory remap register fields
	localparam int MR_CACHE = 2;
	localparam int MR_PF_LO = 3;
	localparam int MR_RD_MODE = 4;
	localparam int MR_AF_LO = 5;
	localparam int MR_MWI = 9;
	localparam int MR_AF_HI = 10;
	localparam int MR_PF_LIMIT = 11;
	localparam int MR_PF_HI = 12;
	localparam int MR_IO_REMAP = 13;
	localparam int MR_WDLY = 14;
	// configuration address fields
	localparam int CF_ENABLE = 31;
	// space 1 fields
	localparam int RG_IO = 0;
	localparam int RM_ENABLE = 0;
	localparam int DS_WS = 2;
	localparam int DS_READY = 6;
	localparam int DS_BTERM = 7;
	localparam int DS_BURST = 8;
	localparam int DS_PF_DIS = 9;
	localparam int DS_CNT_EN = 10;
	localparam int DS_CNT = 11;
	// timing counts in pci clocks, and the write-invalidate fifo minimum in lwords
	localparam logic [4:0] WDLY_4 = 5'd4;
	localparam logic [4:0] WDLY_8 = 5'd8;
	localparam logic [4:0] WDLY_16 = 5'd16;
	localparam logic [5:0] MWI_MIN = 6'd8;
	// write delay sequencer
	typedef enum logic [0:0] {WD_IDLE, WD_WAIT} wdly_state_t;
endpackage : bwc_pkg

// ==== logic/bwc_regs.sv ====
// configuration register bank for the initiator path and space 1
// Operation
// R01 - cache enable prefetches without limit
// R02 - prefetch size selects finish, 4, 8, 16
// R03 - read fifo full: release or hold bus
// R04 - almost full when occupancy exceeds threshold
// R05 - write-invalidate waits for 8/16 words; the code always waits for 8
// R06 - prefetch limit stops at 4 KB boundaries
// R07 - io remap select zeroes upper address
// R08 - burst write delays bus request 0/4/8/16
// R09 - memory remap replaces decoded address bits
// R10 - config enable turns io into config cycles
// R11 - space indicator picks memory or io
// R12 - location field encodes space placement
// R13 - range mask picks decoded bits; 1 MB
// R14 - space 1 decodes only when enabled
// R15 - remap replaces decoded bits for local
// R16 - width field 8/16/32, reset 32
// R17 - insert 0 to 15 wait states
// R18 - ready input enable; bterm enable
// R19 - burst only when burst enable set
// R20 - prefetch disable: disconnect each read
// R21 - count enable limits prefetch to count
// R22 - upper register nonzero gives dual address
// R23 - reserved bits read zero, fields read back
module bwc_regs import bwc_pkg::*; (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// register port
	input wire logic [8:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [3:0] i_reg_be,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_ack,
	// initiator path status from the engines
	input wire logic [5:0] i_wfifo_count,
	input wire logic i_rfifo_full,
	input wire logic [31:0] i_prefetch_addr,
	input wire logic i_wburst_start,
	// initiator address request
	input wire logic [31:0] i_init_local_addr,
	input wire logic [15:0] i_init_range_mask,
	input wire logic i_init_is_io,
	// target address request
	input wire logic [31:0] i_tgt_pci_addr,
	input wire logic [31:0] i_tgt_base,
	input wire logic i_tgt_is_io,
	// space 1 local bus
	input wire logic i_local_ready_input,
	input wire logic i_s1_data_phase,
	// initiator controls
	output logic o_write_fifo_almost_full_out,
	output logic o_mwi_mode,
	output logic o_pci_start_ok,
	output logic o_rd_release_bus,
	output logic o_rd_hold_irdy,
	output logic o_prefetch_unlimited,
	output logic [4:0] o_prefetch_lwords,
	output logic o_prefetch_stop,
	output logic o_pci_req_allow,
	output logic [31:0] o_init_pci_addr,
	output logic [31:0] o_init_upper_addr,
	output logic o_init_cfg_cycle,
	output logic o_init_dual_addr,
	output logic o_dm_mem_en,
	output logic o_dm_io_en,
	// space 1 controls
	output logic o_tgt_hit,
	output logic [31:0] o_tgt_local_addr,
	output logic [1:0] o_s1_width,
	output logic o_s1_wait_busy,
	output logic o_s1_ready,
	output logic o_s1_bterm_en,
	output logic o_s1_burst_en,
	output logic o_s1_disconnect_each,
	output logic o_s1_pf_unlimited,
	output logic [3:0] o_s1_pf_count
);
	// register storage
	logic [31:0] mem_remap_q;
	logic [31:0] cfg_addr_q;
	logic [31:0] s1_range_q;
	logic [31:0] s1_remap_q;
	logic [31:0] s1_desc_q;
	logic [31:0] upper_q;
	// address with the local view folded onto the pci view
	logic [8:0] ofs;
	// read data ahead of its flop
	logic [31:0] rdata_d;
	// ready pin synchroniser
	logic ready_meta_q;
	logic ready_sync_q;
	// write delay sequencer
	wdly_state_t wd_state_q;
	logic [4:0] wd_cnt_q;
	// wait state counter
	logic [3:0] ws_cnt_q;
	// fields pulled out for readability
	logic [1:0] pf_size;
	logic [4:0] af_level;
	logic [1:0] wdly_sel;

	// merge write data into a register under byte enables and writable mask
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] wm);
		logic [31:0] lanes;
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (old & ~(lanes & wm)) | (wd & lanes & wm);
	endfunction : merge

	// pci clocks of delay for each write delay code
	function automatic logic [4:0] wdly_cycles(input logic [1:0] sel);
		case (sel)
			2'b01: wdly_cycles = WDLY_4;
			2'b10: wdly_cycles = WDLY_8;
			2'b11: wdly_cycles = WDLY_16;
			default: wdly_cycles = 5'd0;
		endcase
	endfunction : wdly_cycles

	// the local view repeats the pci view one block higher
	always_comb begin
		// 0x0a8..0x0af holds nothing in the pci view, so it is local view too
		if (i_reg_addr >= 9'h100 || i_reg_addr[8:3] == 6'h15) begin
			ofs = i_reg_addr - OFS_LOCAL_SHIFT;
		end else begin
			ofs = i_reg_addr;
		end
	end

	// split fields spread over non adjacent bits, and the write delay code
	always_comb begin
		pf_size = {mem_remap_q[MR_PF_HI], mem_remap_q[MR_PF_LO]};
		af_level = {mem_remap_q[MR_AF_HI], mem_remap_q[MR_AF_LO+3:MR_AF_LO]};
		wdly_sel = mem_remap_q[MR_WDLY+1:MR_WDLY];
	end

	// initiator memory remap register
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			mem_remap_q <= RST_ZERO;
		end else if (i_reg_wr && ofs == OFS_MEM_REMAP) begin
			mem_remap_q <= merge(mem_remap_q, i_reg_wdata, i_reg_be, WM_ALL);
		end
	end

	// configuration cycle address register
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			cfg_addr_q <= RST_ZERO;
		end else if (i_reg_wr && ofs == OFS_CFG_ADDR) begin
			// bits 30:24 stay zero [R23]
			cfg_addr_q <= merge(cfg_addr_q, i_reg_wdata, i_reg_be, WM_CFG);
		end
	end

	// space 1 range register, defaults to a 1 MB window
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			s1_range_q <= RST_S1_RANGE; // [R13]
		end else if (i_reg_wr && ofs == OFS_S1_RANGE) begin
			s1_range_q <= merge(s1_range_q, i_reg_wdata, i_reg_be, WM_ALL);
		end
	end

	// space 1 remap register with enable in bit 0
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			s1_remap_q <= RST_ZERO;
		end else if (i_reg_wr && ofs == OFS_S1_REMAP) begin
			// bit 1 stays zero [R23]
			s1_remap_q <= merge(s1_remap_q, i_reg_wdata, i_reg_be, WM_S1_REMAP);
		end
	end

	// space 1 bus region descriptor
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			// 32-bit width and ready enabled after reset [R16] [R18]
			s1_desc_q <= RST_S1_DESC;
		end else if (i_reg_wr && ofs == OFS_S1_DESC) begin
			// bits 31:15 stay zero [R23]
			s1_desc_q <= merge(s1_desc_q, i_reg_wdata, i_reg_be, WM_S1_DESC);
		end
	end

	// upper address register for dual address cycles
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			upper_q <= RST_ZERO;
		end else if (i_reg_wr && ofs == OFS_UPPER) begin
			upper_q <= merge(upper_q, i_reg_wdata, i_reg_be, WM_ALL);
		end
	end

	// read multiplexer, unmapped offsets read zero
	always_comb begin
		case (ofs)
			OFS_MEM_REMAP: rdata_d = mem_remap_q;
			OFS_CFG_ADDR: rdata_d = cfg_addr_q;
			OFS_S1_RANGE: rdata_d = s1_range_q;
			OFS_S1_REMAP: rdata_d = s1_remap_q;
			OFS_S1_DESC: rdata_d = s1_desc_q;
			OFS_UPPER: rdata_d = upper_q;
			default: rdata_d = RST_ZERO;
		endcase
	end

	// read data and acknowledge, one cycle after the strobe
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_reg_rdata <= RST_ZERO;
			o_reg_ack <= 1'b0;
		end else begin
			// fields return what was last written [R23]
			if (i_reg_rd) begin
				o_reg_rdata <= rdata_d;
			end
			o_reg_ack <= i_reg_rd | i_reg_wr;
		end
	end

	// write fifo almost full and write-invalidate start gate
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_write_fifo_almost_full_out <= 1'b0;
			o_pci_start_ok <= 1'b0;
		end else begin
			// strictly above the threshold [R04]
			o_write_fifo_almost_full_out <= ({1'b0, af_level} < i_wfifo_count);
			if (mem_remap_q[MR_MWI]) begin
				// hold the pci access until a full line is queued [R05]
				o_pci_start_ok <= (i_wfifo_count >= MWI_MIN);
			end else begin
				o_pci_start_ok <= (i_wfifo_count != 6'd0);
			end
		end
	end

	// read fifo full handling and 4 KB prefetch stop
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_rd_release_bus <= 1'b0;
			o_rd_hold_irdy <= 1'b0;
			o_prefetch_stop <= 1'b0;
		end else begin
			// mode 0 gives the bus up, mode 1 parks with irdy off [R03]
			o_rd_release_bus <= i_rfifo_full & ~mem_remap_q[MR_RD_MODE];
			o_rd_hold_irdy <= i_rfifo_full & mem_remap_q[MR_RD_MODE];
			// last long word before a 4 KB boundary ends prefetch [R06]
			o_prefetch_stop <= mem_remap_q[MR_PF_LIMIT]
				&& (i_prefetch_addr[11:2] == 10'h3ff);
		end
	end

	// prefetch amount for initiator reads
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_prefetch_unlimited <= 1'b1;
			o_prefetch_lwords <= 5'd0;
		end else begin
			// cache enable overrides the size [R01]
			// size 00 runs until the local access ends [R02]
			o_prefetch_unlimited <= mem_remap_q[MR_CACHE] || (pf_size == 2'b00);
			case (pf_size)
				2'b01: o_prefetch_lwords <= 5'd4; // [R02]
				2'b10: o_prefetch_lwords <= 5'd8;
				2'b11: o_prefetch_lwords <= 5'd16;
				default: o_prefetch_lwords <= 5'd0;
			endcase
		end
	end

	// write delay: hold off the bus request after a burst write starts
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			wd_state_q <= WD_IDLE;
			wd_cnt_q <= 5'd0;
		end else begin
			case (wd_state_q)
				WD_IDLE: begin
					// a zero code starts the cycle at once [R08]
					if (i_wburst_start && wdly_sel != 2'b00) begin
						wd_state_q <= WD_WAIT;
						// the start cycle itself is the first delayed clock
						wd_cnt_q <= wdly_cycles(wdly_sel) - 5'd2;
					end
				end
				WD_WAIT: begin
					// count down the programmed pci clocks [R08]
					if (wd_cnt_q == 5'd0) begin
						wd_state_q <= WD_IDLE;
					end else begin
						wd_cnt_q <= wd_cnt_q - 5'd1;
					end
				end
				default: wd_state_q <= WD_IDLE;
			endcase
		end
	end

	// request allowed except while the delay runs
	always_comb begin
		o_pci_req_allow = (wd_state_q == WD_IDLE)
			&& !(i_wburst_start && wdly_sel != 2'b00); // [R08]
	end

	// two flops on the ready pin before anything reads it
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ready_meta_q <= 1'b0;
			ready_sync_q <= 1'b0;
		end else begin
			ready_meta_q <= i_local_ready_input;
			ready_sync_q <= ready_meta_q;
		end
	end

	// internal wait states between space 1 data phases
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ws_cnt_q <= 4'd0;
			o_s1_wait_busy <= 1'b0;
		end else if (i_s1_data_phase) begin
			// load the programmed 0..15 count [R17]
			ws_cnt_q <= s1_desc_q[DS_WS+3:DS_WS];
			o_s1_wait_busy <= (s1_desc_q[DS_WS+3:DS_WS] != 4'd0);
		end else if (ws_cnt_q != 4'd0) begin
			ws_cnt_q <= ws_cnt_q - 4'd1;
			o_s1_wait_busy <= (ws_cnt_q != 4'd1);
		end
	end

	// space 1 ready: the pin counts only when enabled
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_s1_ready <= 1'b0;
		end else begin
			// disabled ready leaves timing to the wait counter [R18]
			o_s1_ready <= s1_desc_q[DS_READY] ? ready_sync_q : 1'b1;
		end
	end

	// space 1 and initiator static controls, driven from their register bits
	always_comb begin
		o_s1_width = s1_desc_q[1:0]; // [R16]
		o_s1_bterm_en = s1_desc_q[DS_BTERM]; // [R18]
		o_s1_burst_en = s1_desc_q[DS_BURST]; // [R19]
		// disconnect follows the prefetch disable bit alone, io or memory [R20]
		o_s1_disconnect_each = s1_desc_q[DS_PF_DIS];
		// count disabled means no count limit [R21]
		o_s1_pf_unlimited = ~s1_desc_q[DS_CNT_EN];
		o_s1_pf_count = s1_desc_q[DS_CNT+3:DS_CNT]; // [R21]
		o_mwi_mode = mem_remap_q[MR_MWI]; // [R05]
		o_dm_mem_en = mem_remap_q[0];
		o_dm_io_en = mem_remap_q[1];
		o_init_upper_addr = upper_q; // [R22]
	end

	// address translation for both paths
	bwc_addr_xlate u_xlate (
		.i_mem_remap(mem_remap_q), .i_cfg_addr(cfg_addr_q), .i_s1_range(s1_range_q),
		.i_s1_remap(s1_remap_q), .i_upper(upper_q), .i_init_local_addr(i_init_local_addr),
		.i_init_range_mask(i_init_range_mask), .i_init_is_io(i_init_is_io),
		.i_tgt_pci_addr(i_tgt_pci_addr), .i_tgt_base(i_tgt_base), .i_tgt_is_io(i_tgt_is_io),
		.o_init_pci_addr(o_init_pci_addr), .o_init_cfg_cycle(o_init_cfg_cycle),
		.o_init_dual_addr(o_init_dual_addr), .o_tgt_hit(o_tgt_hit),
		.o_tgt_local_addr(o_tgt_local_addr));
endmodule : bwc_regs

// ==== tb/bwc_regs_monitor.sv ====
// port assertions for the bridge window configuration bank
module bwc_regs_monitor (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// watched ports
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic o_reg_ack,
	input wire logic [5:0] i_wfifo_count,
	input wire logic i_rfifo_full,
	input wire logic [31:0] i_prefetch_addr,
	input wire logic i_wburst_start,
	input wire logic i_init_is_io,
	input wire logic o_mwi_mode,
	input wire logic o_pci_start_ok,
	input wire logic o_rd_release_bus,
	input wire logic o_rd_hold_irdy,
	input wire logic o_prefetch_unlimited,
	input wire logic [4:0] o_prefetch_lwords,
	input wire logic o_prefetch_stop,
	input wire logic o_pci_req_allow,
	input wire logic [31:0] o_init_upper_addr,
	input wire logic o_init_cfg_cycle,
	input wire logic o_init_dual_addr,
	input wire logic o_s1_wait_busy
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	// a request-delay window opens only on a burst start
	sequence delay_open;
		$fell(o_pci_req_allow) && i_wburst_start;
	endsequence
	// the window holds at least 4 cycles and ends by the 16th
	sequence delay_close;
		!o_pci_req_allow [*3] ##[1:13] $rose(o_pci_req_allow);
	endsequence
	a_ack_follows: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack)
		else $error("ack missing after strobe");
	a_ack_cause: assert property (o_reg_ack |-> $past(i_reg_wr) || $past(i_reg_rd))
		else $error("ack without strobe");
	a_delay_cause: assert property ($fell(o_pci_req_allow) |-> i_wburst_start)
		else $error("request delay without burst start");
	a_delay_len: assert property (delay_open |=> delay_close)
		else $error("request delay length wrong");
	a_wait_len: assert property (o_s1_wait_busy |-> ##[1:15] !o_s1_wait_busy)
		else $error("wait states exceed 15");
	a_fifo_full: assert property ((o_rd_release_bus || o_rd_hold_irdy) == $past(i_rfifo_full)
		&& !(o_rd_release_bus && o_rd_hold_irdy))
		else $error("read fifo full response wrong");
	a_page_stop: assert property (o_prefetch_stop |-> $past(i_prefetch_addr[11:2]) == 10'h3ff)
		else $error("prefetch stop off boundary");
	a_size_limit: assert property (!o_prefetch_unlimited |->
		o_prefetch_lwords inside {5'h04, 5'h08, 5'h10})
		else $error("prefetch size illegal");
	a_mwi_wait: assert property (o_pci_start_ok && $past(o_mwi_mode) |->
		$past(i_wfifo_count) >= 6'h08)
		else $error("invalidate start below 8 lwords");
	a_cfg_io: assert property (o_init_cfg_cycle |-> i_init_is_io)
		else $error("config cycle on memory access");
	a_dual_zero: assert property (o_init_dual_addr == (o_init_upper_addr != 32'h0000_0000))
		else $error("dual address flag wrong");
endmodule : bwc_regs_monitor
bind bwc_regs bwc_regs_monitor mon_u (.*);

// ==== tb/local_side_model.sv ====
// local side model: ready pin, data phase strobe, write fifo level
module local_side_model (
	// clock
	input wire logic i_sys_clk,
	// commands from the bench
	input wire logic i_phase_go,
	input wire logic i_stall,
	input wire logic i_push8,
	input wire logic i_drain,
	// towards the bank
	output logic o_ready,
	output logic o_phase,
	output logic [5:0] o_count
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle state: slave ready, no phase, fifo empty
	initial begin
		o_ready = 1'b1;
		o_phase = 1'b0;
		o_count = 6'h00;
	end
	// ready pin drops while the local slave stalls
	always @(posedge i_sys_clk) begin
		o_ready <= ~i_stall;
	end
	// one data phase strobe per request
	always @(posedge i_sys_clk) begin
		o_phase <= i_phase_go;
	end
	// the local master writes whole 8-lword bursts only
	always @(posedge i_sys_clk) begin
		if (i_drain) begin
			o_count <= 6'h00;
		end else if (i_push8 && o_count < 6'h20) begin
			o_count <= o_count + 6'h08;
		end
	end
endmodule : local_side_model

// ==== tb/test_bwc_regs.sv ====
// self-checking bench for the bridge window configuration bank
module test_bwc_regs import bwc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus and observed ports
	logic i_sys_clk, i_reset, i_reg_wr, i_reg_rd, i_rfifo_full, i_wburst_start, i_init_is_io;
	logic i_tgt_is_io, i_local_ready_input, i_s1_data_phase, o_reg_ack;
	logic o_write_fifo_almost_full_out, o_mwi_mode, o_pci_start_ok, o_rd_release_bus;
	logic o_rd_hold_irdy, o_prefetch_unlimited, o_prefetch_stop, o_pci_req_allow;
	logic o_init_cfg_cycle, o_init_dual_addr, o_tgt_hit, o_s1_wait_busy, o_s1_ready;
	logic o_s1_bterm_en, o_s1_burst_en, o_s1_disconnect_each, o_s1_pf_unlimited;
	logic [8:0] i_reg_addr;
	logic [3:0] i_reg_be, o_s1_pf_count;
	logic [31:0] i_reg_wdata, o_reg_rdata, i_prefetch_addr, i_init_local_addr, i_tgt_pci_addr;
	logic [31:0] i_tgt_base, o_init_pci_addr, o_init_upper_addr, o_tgt_local_addr;
	logic [15:0] i_init_range_mask;
	logic [5:0] i_wfifo_count;
	logic [4:0] o_prefetch_lwords;
	logic [1:0] o_s1_width;
	logic o_dm_mem_en, o_dm_io_en;
	// model commands and bookkeeping
	logic phase_go, stall, push8, drain;
	int fail_count, compares;
	// offsets, reset values and writable masks of the six registers
	logic [8:0] ofs [6] = '{OFS_MEM_REMAP, OFS_CFG_ADDR, OFS_S1_RANGE, OFS_S1_REMAP,
		OFS_S1_DESC, OFS_UPPER};
	logic [31:0] rst_v [6] = '{RST_ZERO, RST_ZERO, RST_S1_RANGE, RST_ZERO, RST_S1_DESC, RST_ZERO};
	logic [31:0] wm_v [6] = '{WM_ALL, WM_CFG, WM_ALL, WM_S1_REMAP, WM_S1_DESC, WM_ALL};
	bwc_regs dut_u (.*);
	local_side_model model_u (.i_sys_clk, .i_phase_go(phase_go), .i_stall(stall),
		.i_push8(push8), .i_drain(drain), .o_ready(i_local_ready_input),
		.o_phase(i_s1_data_phase), .o_count(i_wfifo_count));
	// 125 MHz clock
	initial begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	// verdict and end of run
	task automatic give_verdict;
		if (fail_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	// compare one value
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// let registered effects land
	task automatic settle;
		repeat (3) @(posedge i_sys_clk);
		#1;
	endtask : settle
	// bounded wait for the access acknowledge
	task automatic wait_ack;
		int n = 0;
		#1;
		while (o_reg_ack !== 1'b1 && n < 8) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		if (o_reg_ack !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED %0t no acknowledge", $time);
			give_verdict();
		end
	endtask : wait_ack
	// one register write, all lanes
	task automatic reg_write(input logic [8:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_be <= 4'hf;
		i_reg_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_wr <= 1'b0;
		wait_ack();
	endtask : reg_write
	// one register read compared with its expected value
	task automatic rd_chk(input logic [8:0] a, input logic [31:0] e);
		@(posedge i_sys_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_reg_rd <= 1'b0;
		wait_ack();
		chk(o_reg_rdata, e);
	endtask : rd_chk
	// synchronous reset held for two cycles
	task automatic do_reset;
		@(posedge i_sys_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_reset <= 1'b0;
	endtask : do_reset
	// one 8-lword burst into the write fifo
	task automatic push;
		@(posedge i_sys_clk);
		push8 <= 1'b1;
		@(posedge i_sys_clk);
		push8 <= 1'b0;
		settle();
	endtask : push
	// reset values, all-ones via local view, read back in pci view
	task automatic t_regs;
		for (int i = 0; i < 6; i++) begin
			rd_chk(ofs[i], rst_v[i]);
			reg_write(ofs[i] + OFS_LOCAL_SHIFT, 32'hffff_ffff);
			rd_chk(ofs[i], wm_v[i]);
		end
		reg_write(9'h030, 32'hffff_ffff);
		rd_chk(9'h030, 32'h0000_0000);
	endtask : t_regs
	// almost-full threshold 16 with write-and-invalidate on
	task automatic t_fifo;
		reg_write(OFS_MEM_REMAP, 32'h0000_0600);
		settle();
		chk(o_pci_start_ok, 1'b0);
		push();
		chk({o_mwi_mode, o_pci_start_ok}, 2'b11);
		push();
		chk(o_write_fifo_almost_full_out, 1'b0);
		push();
		chk(o_write_fifo_almost_full_out, 1'b1);
		@(posedge i_sys_clk);
		drain <= 1'b1;
		@(posedge i_sys_clk);
		drain <= 1'b0;
	endtask : t_fifo
	// request delay length for every code
	task automatic t_delay;
		int n;
		for (int c = 0; c < 4; c++) begin
			reg_write(OFS_MEM_REMAP, 32'(c) << 14);
			@(posedge i_sys_clk);
			i_wburst_start <= 1'b1;
			#1;
			n = 0;
			while (o_pci_req_allow === 1'b0 && n < 40) begin
				@(posedge i_sys_clk);
				i_wburst_start <= 1'b0;
				#1;
				n++;
			end
			@(posedge i_sys_clk);
			i_wburst_start <= 1'b0;
			chk(n, (c == 0) ? 0 : 4 << (c - 1));
		end
	endtask : t_delay
	// prefetch size codes, cache, page limit, read fifo full modes
	task automatic t_prefetch;
		logic [4:0] lw [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
		for (int c = 0; c < 4; c++) begin
			reg_write(OFS_MEM_REMAP, {19'h0_0000, c[1], 8'h00, c[0], 3'h0});
			settle();
			chk(o_prefetch_unlimited, c == 0);
			chk(o_prefetch_lwords, lw[c]);
		end
		@(posedge i_sys_clk);
		i_prefetch_addr <= 32'h0000_1ffc;
		i_rfifo_full <= 1'b1;
		reg_write(OFS_MEM_REMAP, 32'h0000_181c);
		settle();
		chk(o_prefetch_unlimited, 1'b1);
		chk(o_prefetch_stop, 1'b1);
		chk({o_rd_release_bus, o_rd_hold_irdy}, 2'b01);
		@(posedge i_sys_clk);
		i_prefetch_addr <= 32'h0000_1ff8;
		reg_write(OFS_MEM_REMAP, 32'h0000_180c);
		settle();
		chk(o_prefetch_stop, 1'b0);
		chk({o_rd_release_bus, o_rd_hold_irdy}, 2'b10);
		@(posedge i_sys_clk);
		i_rfifo_full <= 1'b0;
	endtask : t_prefetch
	// initiator address forming
	task automatic t_addr;
		@(posedge i_sys_clk);
		i_init_is_io <= 1'b1;
		i_init_local_addr <= 32'h5555_abcd;
		i_init_range_mask <= 16'hff00;
		reg_write(OFS_MEM_REMAP, 32'h1234_0000);
		chk(o_init_pci_addr, 32'h1234_abcd);
		reg_write(OFS_MEM_REMAP, 32'h1234_2003);
		chk({o_dm_mem_en, o_dm_io_en, o_init_pci_addr}, {2'b11, 32'h0000_abcd});
		@(posedge i_sys_clk);
		i_init_is_io <= 1'b0;
		#1;
		chk(o_init_pci_addr, 32'h1255_abcd);
		reg_write(OFS_CFG_ADDR, 32'h8012_3405);
		chk(o_init_cfg_cycle, 1'b0);
		@(posedge i_sys_clk);
		i_init_is_io <= 1'b1;
		#1;
		chk({o_init_cfg_cycle, o_init_pci_addr}, {1'b1, 32'h0012_3405});
		chk(o_init_dual_addr, 1'b0);
		reg_write(OFS_UPPER, 32'hdead_0001);
		chk({o_init_dual_addr, o_init_upper_addr}, {1'b1, 32'hdead_0001});
	endtask : t_addr
	// space 1 decode and remap, memory then i/o
	task automatic t_target;
		@(posedge i_sys_clk);
		i_tgt_pci_addr <= 32'h1234_5678;
		i_tgt_base <= 32'h1230_0000;
		reg_write(OFS_S1_REMAP, 32'habc0_0000);
		chk(o_tgt_hit, 1'b0);
		reg_write(OFS_S1_REMAP, 32'habc0_0001);
		chk({o_tgt_hit, o_tgt_local_addr}, {1'b1, 32'habc4_5678});
		@(posedge i_sys_clk);
		i_tgt_is_io <= 1'b1;
		i_tgt_base <= 32'h1234_5678;
		#1;
		chk(o_tgt_hit, 1'b0);
		reg_write(OFS_S1_RANGE, 32'hffff_fffd);
		reg_write(OFS_S1_REMAP, 32'habcd_ef0d);
		chk({o_tgt_hit, o_tgt_local_addr}, {1'b1, 32'habcd_ef0c});
	endtask : t_target
	// space 1 descriptor fields, wait states and ready enable
	task automatic t_local;
		int n = 0;
		reg_write(OFS_S1_DESC, 32'h0000_2fcd);
		chk({o_s1_width, o_s1_bterm_en, o_s1_burst_en}, 4'b0111);
		chk({o_s1_disconnect_each, o_s1_pf_unlimited, o_s1_pf_count}, 6'b10_0101);
		@(posedge i_sys_clk);
		phase_go <= 1'b1;
		@(posedge i_sys_clk);
		phase_go <= 1'b0;
		repeat (12) begin
			@(posedge i_sys_clk);
			#1;
			n += (o_s1_wait_busy === 1'b1);
		end
		chk(n, 3);
		@(posedge i_sys_clk);
		stall <= 1'b1;
		settle();
		settle();
		chk(o_s1_ready, 1'b0);
		reg_write(OFS_S1_DESC, 32'h0000_2f8d);
		settle();
		chk(o_s1_ready, 1'b1);
		@(posedge i_sys_clk);
		stall <= 1'b0;
		reg_write(OFS_S1_DESC, 32'h0000_0000);
		chk({o_s1_width, o_s1_burst_en, o_s1_pf_unlimited}, 4'b0001);
	endtask : t_local
	// run cut short if anything hangs
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		fail_count++;
		$display("CHECK FAILED %0t run timed out", $time);
		give_verdict();
	end
	// main sequence
	initial begin
		{i_reg_wr, i_reg_rd, i_rfifo_full, i_wburst_start, i_init_is_io, i_tgt_is_io} = '0;
		{phase_go, stall, push8, drain, fail_count, compares} = '0;
		{i_reg_addr, i_reg_be, i_reg_wdata, i_prefetch_addr} = '0;
		{i_init_local_addr, i_init_range_mask, i_tgt_pci_addr, i_tgt_base} = '0;
		i_reset = 1'b1;
		do_reset();
		t_regs();
		do_reset();
		rd_chk(OFS_S1_DESC, 32'h0000_0043);
		t_fifo();
		t_delay();
		t_prefetch();
		t_addr();
		t_target();
		t_local();
		give_verdict();
	end
endmodule : test_bwc_regs
